// ===== pgm_mask_bank.sv
// power-good tree mask bank for the second and third good outputs
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// ********************************
// What this block does
// [RQ1] output good only when every unmasked source good
// [RQ2] bit 7 masks second adjustable regulator
// [RQ3] bit 6 masks group A switch one
// [RQ4] bits 5..0 mask step-down rails six..one
// [RQ5] second output pin mask at A9h, eight bits
// [RQ6] bits 7..4 mask control inputs 5,4,2,1
// [RQ7] bit 3 masks memory termination regulator
// [RQ8] bit 2 masks shared otp-selected good signal
// [RQ9] bit 1 masks group B switch one
// [RQ10] bit 0 masks third adjustable regulator
// [RQ11] third output rail mask at AAh
// [RQ12] third rail mask uses same bit layout
// [RQ13] third output pin mask at ABh
// [RQ14] second output rail mask at A8h
// [RQ15] masks reset to otp defaults, writes override
// ********************************
module pgm_mask_bank
  import pgm_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [DATA_WIDTH-1:0]   s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [DATA_WIDTH-1:0]        s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [MASK_WIDTH-1:0]   otp_second_rail_mask,
  input  wire logic [MASK_WIDTH-1:0]   otp_second_pin_mask,
  input  wire logic [MASK_WIDTH-1:0]   otp_third_rail_mask,
  input  wire logic [MASK_WIDTH-1:0]   otp_third_pin_mask,
  input  wire logic                    otp_shared_from_regulator,
  input  wire logic [5:0]              step_down_rail_good,
  input  wire logic                    first_adjustable_regulator_good,
  input  wire logic                    second_adjustable_regulator_good,
  input  wire logic                    third_adjustable_regulator_good,
  input  wire logic                    group_a_switch_one_good,
  input  wire logic                    group_b_switch_one_good,
  input  wire logic                    group_b_switch_two_good,
  input  wire logic                    memory_termination_regulator_good,
  input  wire logic                    control_input_one,
  input  wire logic                    control_input_two,
  input  wire logic                    control_input_four,
  input  wire logic                    control_input_five,
  output logic                         second_good_output,
  output logic                         third_good_output
);

  // ********************************
  // helper functions
  // ********************************
  // a set mask bit forces its source to count as good
  function automatic logic tree_good(input logic [MASK_WIDTH-1:0] src,
                                     input logic [MASK_WIDTH-1:0] mask);
    tree_good = &(src | mask);
  endfunction : tree_good

  // returns {hit, select}; upper address bits must be zero
  function automatic logic [2:0] decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    decode = 3'h0;
    if (addr[ADDR_WIDTH-1:10] == '0) begin
      unique case (idx)
        IDX_SECOND_OUTPUT_RAIL_MASK_A: decode = 3'h4;
        IDX_SECOND_OUTPUT_PIN_MASK_B:  decode = 3'h5;
        IDX_THIRD_OUTPUT_RAIL_MASK_A:  decode = 3'h6;
        IDX_THIRD_OUTPUT_PIN_MASK_B:   decode = 3'h7;
        default:                       decode = 3'h0;
      endcase
    end
  endfunction : decode

  // ********************************
  // source synchronisers
  // ********************************
  logic [13:0] src_raw;
  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;
  logic [13:0] sync1_next;
  logic [13:0] sync2_next;
  logic [MASK_WIDTH-1:0] rail_src;
  logic [MASK_WIDTH-1:0] pin_src;
  logic                  shared_good;

  assign src_raw = {control_input_five, control_input_four, control_input_two,
                    control_input_one, memory_termination_regulator_good,
                    group_b_switch_two_good, first_adjustable_regulator_good,
                    group_b_switch_one_good, third_adjustable_regulator_good,
                    second_adjustable_regulator_good, group_a_switch_one_good,
                    step_down_rail_good[5:3]};

  always_comb begin
    sync1_next = src_raw;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge aclk) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
  end

  logic [2:0] low_rail1_reg;
  logic [2:0] low_rail2_reg;
  logic [2:0] low_rail1_next;
  logic [2:0] low_rail2_next;

  always_comb begin
    low_rail1_next = step_down_rail_good[2:0];
    low_rail2_next = low_rail1_reg;
  end

  always_ff @(posedge aclk) begin
    low_rail1_reg <= low_rail1_next;
    low_rail2_reg <= low_rail2_next;
  end

  // [RQ8] shared source select
  assign shared_good = otp_shared_from_regulator ? sync2_reg[7] : sync2_reg[8];

  // [RQ2] [RQ3] [RQ4] rail source order
  assign rail_src = {sync2_reg[4], sync2_reg[3], sync2_reg[2:0], low_rail2_reg};

  // [RQ6] [RQ7] [RQ9] [RQ10] pin source order
  assign pin_src = {sync2_reg[13], sync2_reg[12], sync2_reg[11], sync2_reg[10],
                    sync2_reg[9], shared_good, sync2_reg[6], sync2_reg[5]};

  // ********************************
  // write channel
  // ********************************
  logic                  awready_reg, awready_next;
  logic                  wready_reg, wready_next;
  logic                  aw_held_reg, aw_held_next;
  logic                  w_held_reg, w_held_next;
  logic [ADDR_WIDTH-1:0] aw_addr_reg, aw_addr_next;
  logic [MASK_WIDTH-1:0] w_data_reg, w_data_next;
  logic                  w_strb_reg, w_strb_next;
  logic                  bvalid_reg, bvalid_next;
  logic [1:0]            bresp_reg, bresp_next;
  logic [MASK_WIDTH-1:0] mask_reg [4];
  logic [MASK_WIDTH-1:0] mask_next [4];
  logic [2:0]            wr_dec;
  logic                  commit;

  assign wr_dec = decode(aw_addr_reg);
  // only one response outstanding; a held pair waits for bready
  assign commit = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    for (int i = 0; i < 4; i++) begin
      mask_next[i] = mask_reg[i];
    end
    if (s_axi_awvalid & awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid & wready_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata[MASK_WIDTH-1:0];
      w_strb_next = s_axi_wstrb[0];
    end
    if (s_axi_bready & bvalid_reg) begin
      bvalid_next = 1'b0;
    end
    if (commit) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_dec[2] ? RESP_OKAY : RESP_DECERR;
      // [RQ5] [RQ11] [RQ13] [RQ14] mapped write
      // [RQ15] write overrides default
      if (wr_dec[2] & w_strb_reg) begin
        mask_next[wr_dec[1:0]] = w_data_reg;
      end
    end
    awready_next = ~aw_held_next;
    wready_next  = ~w_held_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      // [RQ15] otp defaults at reset
      mask_reg[0] <= otp_second_rail_mask;
      mask_reg[1] <= otp_second_pin_mask;
      mask_reg[2] <= otp_third_rail_mask;
      mask_reg[3] <= otp_third_pin_mask;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      for (int i = 0; i < 4; i++) begin
        mask_reg[i] <= mask_next[i];
      end
    end
  end

  // ********************************
  // read channel
  // ********************************
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg, rvalid_next;
  logic [DATA_WIDTH-1:0] rdata_reg, rdata_next;
  logic [1:0]            rresp_reg, rresp_next;
  logic [2:0]            rd_dec;

  assign rd_dec = decode(s_axi_araddr);

  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_arvalid & arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = rd_dec[2] ? RESP_OKAY : RESP_DECERR;
      rdata_next   = RDATA_RESET;
      if (rd_dec[2]) begin
        rdata_next[MASK_WIDTH-1:0] = mask_reg[rd_dec[1:0]];
      end
    end else if (rvalid_reg & s_axi_rready) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end else if (!rvalid_reg) begin
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= RDATA_RESET;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ********************************
  // power-good trees
  // ********************************
  logic second_good_reg, second_good_next;
  logic third_good_reg, third_good_next;

  always_comb begin
    // [RQ1] second output tree
    second_good_next = tree_good(rail_src, mask_reg[0]) & tree_good(pin_src, mask_reg[1]);
    // [RQ12] [RQ13] third output tree, same layout
    third_good_next  = tree_good(rail_src, mask_reg[2]) & tree_good(pin_src, mask_reg[3]);
  end

  // outputs hold not-good through reset so no false good escapes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_good_reg <= 1'b0;
      third_good_reg  <= 1'b0;
    end else begin
      second_good_reg <= second_good_next;
      third_good_reg  <= third_good_next;
    end
  end

  assign s_axi_awready      = awready_reg;
  assign s_axi_wready       = wready_reg;
  assign s_axi_bvalid       = bvalid_reg;
  assign s_axi_bresp        = bresp_reg;
  assign s_axi_arready      = arready_reg;
  assign s_axi_rvalid       = rvalid_reg;
  assign s_axi_rdata        = rdata_reg;
  assign s_axi_rresp        = rresp_reg;
  assign second_good_output = second_good_reg;
  assign third_good_output  = third_good_reg;

endmodule : pgm_mask_bank

// ===== pgm_pkg.sv
// constants for the power-good tree mask bank
package pgm_pkg;

  // ********************************
  // bus geometry
  // ********************************
  localparam int unsigned ADDR_WIDTH = 12;
  localparam int unsigned DATA_WIDTH = 32;
  localparam int unsigned MASK_WIDTH = 8;

  // ********************************
  // register indices, byte address is four times the index
  // ********************************
  localparam logic [7:0] IDX_SECOND_OUTPUT_RAIL_MASK_A = 8'hA8;
  localparam logic [7:0] IDX_SECOND_OUTPUT_PIN_MASK_B  = 8'hA9;
  localparam logic [7:0] IDX_THIRD_OUTPUT_RAIL_MASK_A  = 8'hAA;
  localparam logic [7:0] IDX_THIRD_OUTPUT_PIN_MASK_B   = 8'hAB;

  // ********************************
  // rail mask field positions
  // ********************************
  localparam int unsigned BIT_SECOND_REGULATOR = 7;
  localparam int unsigned BIT_GROUP_A_SWITCH   = 6;
  localparam int unsigned BIT_STEP_DOWN_HIGH   = 5;
  localparam int unsigned BIT_STEP_DOWN_LOW    = 0;

  // ********************************
  // pin mask field positions
  // ********************************
  localparam int unsigned BIT_CONTROL_FIVE     = 7;
  localparam int unsigned BIT_CONTROL_FOUR     = 6;
  localparam int unsigned BIT_CONTROL_TWO      = 5;
  localparam int unsigned BIT_CONTROL_ONE      = 4;
  localparam int unsigned BIT_TERMINATION      = 3;
  localparam int unsigned BIT_SHARED           = 2;
  localparam int unsigned BIT_GROUP_B_ONE      = 1;
  localparam int unsigned BIT_THIRD_REGULATOR  = 0;

  // ********************************
  // sync depth, reset and response values
  // ********************************
  localparam int unsigned SYNC_STAGES          = 2;
  localparam logic [1:0]  RESP_OKAY            = 2'h0;
  localparam logic [1:0]  RESP_DECERR          = 2'h3;
  localparam logic [DATA_WIDTH-1:0] RDATA_RESET = 32'h0000_0000;

endpackage : pgm_pkg

// ===== pgm_sys_model.sv
// system side model that watches the two good outputs
`timescale 1ns/1ps
module pgm_sys_model (
  input  wire logic       aclk,
  input  wire logic       second_good_output,
  input  wire logic       third_good_output,
  output logic [1:0]      seen_good
);
  logic [1:0] seen_reg;
  logic [1:0] seen_next;
  always_comb seen_next = {third_good_output, second_good_output};
  always_ff @(posedge aclk) seen_reg <= seen_next;
  assign seen_good = seen_reg;
endmodule : pgm_sys_model

// ===== pgm_mask_bank_chk.sv
// bus protocol checker for the mask bank
`timescale 1ns/1ps
module pgm_mask_bank_chk
  import pgm_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [DATA_WIDTH-1:0] s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready
);
  // ********************************
  // helpers
  // ********************************
  // only the four word addresses answer, upper bits must be zero
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a);
    return a[11:10] == 2'h0 && a[9:4] == 6'h2A;
  endfunction : hit
  wire ar_t = s_axi_arvalid && s_axi_arready;
  wire aw_t = s_axi_awvalid && s_axi_awready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ********************************
  // assertions
  // ********************************
  a_rd_answer: assert property (ar_t |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_rd_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");
  a_rd_unmapped: assert property (ar_t && !hit(s_axi_araddr) |=>
      s_axi_rresp == RESP_DECERR && s_axi_rdata == RDATA_RESET)
    else $error("unmapped read not refused");
  a_rd_mapped: assert property (ar_t && hit(s_axi_araddr) |=> s_axi_rresp == RESP_OKAY)
    else $error("mapped read refused");
  a_rd_resp_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held after handshake");
  a_rd_one_open: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted while answer open");
  a_wr_unmapped: assert property (aw_t && !hit(s_axi_awaddr) |->
      ##[1:8] (s_axi_bvalid && s_axi_bresp == RESP_DECERR))
    else $error("unmapped write not refused");
  a_wr_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer held after handshake");
  a_aw_ready_fall: assert property (aw_t |=> !s_axi_awready)
    else $error("address ready stayed high after take");
  c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
endmodule : pgm_mask_bank_chk
bind pgm_mask_bank pgm_mask_bank_chk u_chk (.*);

// ===== testbench.sv
// register and good-tree tests for the mask bank
`timescale 1ns/1ps
module testbench;
  import pgm_pkg::*;
  logic                  aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_rready, otp_shared_from_regulator;
  logic [ADDR_WIDTH-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_WIDTH-1:0] s_axi_wdata;
  logic [3:0]            s_axi_wstrb;
  logic [16:0]           src;
  logic [7:0]            mk [4];
  logic [7:0]            otp_second_rail_mask = 8'hA5;
  logic [7:0]            otp_second_pin_mask = 8'h3C;
  logic [7:0]            otp_third_rail_mask = 8'h5A;
  logic [7:0]            otp_third_pin_mask = 8'hC3;
  wire                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]             s_axi_bresp, s_axi_rresp, seen;
  wire [DATA_WIDTH-1:0]  s_axi_rdata;
  wire                   second_good_output, third_good_output;
  wire [5:0]             step_down_rail_good;
  wire                   first_adjustable_regulator_good, second_adjustable_regulator_good;
  wire                   third_adjustable_regulator_good, group_a_switch_one_good;
  wire                   group_b_switch_one_good, group_b_switch_two_good;
  wire                   memory_termination_regulator_good, control_input_one;
  wire                   control_input_two, control_input_four, control_input_five;
  int                    bad_count = 0;
  int                    n_checks = 0;
  // source order matches mask bits: rail mask in 7:0, pin mask in 15:8
  assign {first_adjustable_regulator_good, control_input_five, control_input_four,
    control_input_two, control_input_one, memory_termination_regulator_good,
    group_b_switch_two_good, group_b_switch_one_good, third_adjustable_regulator_good,
    second_adjustable_regulator_good, group_a_switch_one_good, step_down_rail_good} = src;
  pgm_mask_bank u_pgm_mask_bank (.*);
  pgm_sys_model u_pgm_sys_model (.aclk(aclk), .second_good_output(second_good_output),
    .third_good_output(third_good_output), .seen_good(seen));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ********************************
  // tasks
  // ********************************
  function automatic logic [11:0] adr(input int i);
    return 12'h2A0 + 12'(4 * i);
  endfunction : adr
  function automatic logic good(input logic [16:0] s, input logic [7:0] rm,
                                input logic [7:0] pm, input logic sel);
    logic [7:0] p;
    p = s[15:8];
    p[2] = sel ? s[16] : s[10];
    return &(s[7:0] | rm) & &(p | pm);
  endfunction : good
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic final_report;
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    int   n;
    logic ga, gw;
    n = 0;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && !ga) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && !gw) s_axi_wvalid <= 1'b0;
      ga = ga | s_axi_awready;
      gw = gw | s_axi_wready;
    end while (!(ga && gw) && n < 50);
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 50);
    // a response that never came must not pass as a stale okay
    chk("bvalid", {31'h0, s_axi_bvalid}, 32'h0000_0001);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 50);
    chk("rvalid", {31'h0, s_axi_rvalid}, 32'h0000_0001);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic setm(input int i, input logic [7:0] v);
    mk[i] = v;
    // upper data bits carry junk that the bank must drop
    wr(adr(i), {24'hC0_FFEE, v}, 4'h1, RESP_OKAY);
  endtask : setm
  task automatic settle(input logic sel);
    repeat (6) @(posedge aclk);
    chk("second_good", {31'h0, seen[0]}, {31'h0, good(src, mk[0], mk[1], sel)});
    chk("third_good", {31'h0, seen[1]}, {31'h0, good(src, mk[2], mk[3], sel)});
  endtask : settle
  // ********************************
  // main sequence
  // ********************************
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    src = '1;
    otp_shared_from_regulator = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(adr(0), {24'h00_0000, otp_second_rail_mask}, RESP_OKAY);
    rd(adr(1), {24'h00_0000, otp_second_pin_mask}, RESP_OKAY);
    rd(adr(2), {24'h00_0000, otp_third_rail_mask}, RESP_OKAY);
    rd(adr(3), {24'h00_0000, otp_third_pin_mask}, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      setm(i, 8'h00);
      wr(adr(i), 32'h0000_00FF, 4'h0, RESP_OKAY);
      rd(adr(i), 32'h0000_0000, RESP_OKAY);
    end
    wr(12'h29C, 32'h0000_00FF, 4'h1, RESP_DECERR);
    wr(12'h6A0, 32'h0000_00FF, 4'h1, RESP_DECERR);
    rd(adr(0), 32'h0000_0000, RESP_OKAY);
    rd(12'h6A0, 32'h0000_0000, RESP_DECERR);
    rd(12'h2B0, 32'h0000_0000, RESP_DECERR);
    for (int s = 0; s < 2; s++) begin
      otp_shared_from_regulator <= s[0];
      for (int b = 0; b < 16; b++) begin
        src <= ~(17'h0_0001 << ((b == 10 && s == 1) ? 16 : b));
        settle(s[0]);
        setm(b / 8, 8'h01 << (b % 8));
        settle(s[0]);
        setm(b / 8, 8'h00);
        setm(2 + b / 8, 8'h01 << (b % 8));
        settle(s[0]);
        setm(2 + b / 8, 8'h00);
      end
    end
    // mid-run reset must bring the one-time defaults back over the writes
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    mk = '{otp_second_rail_mask, otp_second_pin_mask,
           otp_third_rail_mask, otp_third_pin_mask};
    rd(adr(1), {24'h00_0000, otp_second_pin_mask}, RESP_OKAY);
    settle(1'b1);
    final_report;
  end
  // a run still going after 20000 cycles ends here as a failure
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    final_report;
  end
endmodule : testbench
